// ---- include/rtd_pkg.sv ----
// Purpose: Constants and carrier types for the transmitter driver configuration bank
// Assumes: Byte-wide register port, single clock
// Notes: Offsets are the printed register addresses
`default_nettype none
package rtd_pkg;
	localparam logic [7:0] ADDR_DRIVER_MODE = 8'h28;
	localparam logic [7:0] ADDR_CARRIER_AMPLITUDE = 8'h29;
	localparam logic [7:0] ADDR_MODULATION_CONTROL = 8'h2A;
	localparam logic [7:0] ADDR_OVERSHOOT_AND_LOAD = 8'h2B;
	// Writable bit masks; reserved bits read zero
	localparam logic [7:0] MASK_DRIVER_MODE = 8'hCF;
	localparam logic [7:0] MASK_CARRIER_AMPLITUDE = 8'hDF;
	// Reset values
	localparam logic [7:0] RST_DRIVER_MODE = 8'h00;
	localparam logic [7:0] RST_CARRIER_AMPLITUDE = 8'h00;
	localparam logic [7:0] RST_MODULATION_CONTROL = 8'h00;
	localparam logic [7:0] RST_OVERSHOOT_AND_LOAD = 8'h00;
	// Field positions
	localparam int POS_SECOND_POL = 7;
	localparam int POS_FIRST_POL = 6;
	localparam int POS_OUTPUT_ON = 3;
	localparam int POS_FULL_SWING = 3;
	localparam int POS_MOD_POL = 2;
	// Output style codes
	localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h0;
	localparam logic [2:0] STYLE_PUSH_PULL = 3'h1;
	localparam logic [2:0] STYLE_HIGH_Z = 3'h2;
	localparam logic [2:0] STYLE_UNSUPPORTED_A = 3'h3;
	localparam logic [2:0] STYLE_FIXED_HIGH = 3'h4;
	localparam logic [2:0] STYLE_FIXED_LOW = 3'h5;
	localparam logic [2:0] STYLE_UNSUPPORTED_B = 3'h6;
	// Modulation source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_ENVELOPE = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	// Carrier reduction in mV per level code
	localparam logic [10:0] DROP_MV_0 = 11'h064;
	localparam logic [10:0] DROP_MV_1 = 11'h0FA;
	localparam logic [10:0] DROP_MV_2 = 11'h1F4;
	localparam logic [10:0] DROP_MV_3 = 11'h3E8;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtd_req_t;

	// Analog control word handed to the driver stage
	typedef struct packed {
		logic full_swing;
		logic [10:0] carrier_drop_mv;
		logic [4:0] residual_level;
		logic [3:0] load_current_trim;
		logic [3:0] overshoot_len_first;
		logic [3:0] overshoot_len_second;
	} rtd_analog_t;
endpackage : rtd_pkg
`default_nettype wire

// ---- hw/rtd_bank.sv ----
// Purpose: Transmitter driver configuration registers and antenna pin control
// Assumes: One clock; modulation inputs already synchronous except the external pin
// Notes: Overshoot pulse is counted in system clocks standing in for carrier clocks
//
// The address-and-strobe port was decided locally.
`default_nettype none

// Contract
// (RULE_01) Driver-on bit enables both antenna outputs; off means neither is driven.
// (RULE_02) Second-output polarity bit inverts the second antenna pin.
// (RULE_03) First-output polarity bit inverts the first antenna pin.
// (RULE_04) Software never writes output style codes 011b or 110b.
// (RULE_05) Output style picks open-drain, push-pull, high-Z, fixed high or fixed low.
// (RULE_06) Carrier level code 0..3 lowers amplitude 100, 250, 500, 1000 mV.
// (RULE_07) Full-swing bit drives maximum amplitude, ignoring carrier level code.
// (RULE_08) Modulation polarity bit inverts the selected modulation signal.
// (RULE_09) Source code: 00 none, 01 envelope, 10 external input, 11 reserved.
// (RULE_10) Overshoot modulation lasts second-length field carrier periods.
// (RULE_11) Load register upper nibble holds first overshoot length for phase one.
// (RULE_12) Load current trim nibble adjusts the modulation index.
// (RULE_13) Residual level field sets the residual carrier during modulation.
// (RULE_14) Reserved bits read zero and ignore writes.
module rtd_bank (
	input wire logic clock,
	input wire logic rst,
	input wire rtd_pkg::rtd_req_t req,
	output logic [7:0] rdata,
	input wire logic internal_envelope_signal,
	input wire logic external_modulation_input,
	output logic antenna_drive_a_out,
	output logic antenna_drive_a_oe,
	output logic antenna_drive_b_out,
	output logic antenna_drive_b_oe,
	output logic modulation_active,
	output logic overshoot_active,
	output rtd_pkg::rtd_analog_t analog
);
	import rtd_pkg::*;

	logic [7:0] driver_mode;
	logic [7:0] carrier_amplitude;
	logic [7:0] modulation_control;
	logic [7:0] overshoot_and_load;
	logic ext_meta;
	logic ext_sync;
	logic mod_sel;
	logic mod_prev;
	logic [3:0] os_count;
	logic os_phase_first;
	logic [2:0] style;
	logic drive_a;
	logic drive_b;
	logic next_a_out;
	logic next_a_oe;
	logic next_b_out;
	logic next_b_oe;

	// Register writes; reserved bits masked so they stay zero
	always_ff @(posedge clock) begin
		if (rst) begin
			driver_mode <= RST_DRIVER_MODE;
			carrier_amplitude <= RST_CARRIER_AMPLITUDE;
			modulation_control <= RST_MODULATION_CONTROL;
			overshoot_and_load <= RST_OVERSHOOT_AND_LOAD;
		end else if (req.wr) begin
			case (req.addr)
				ADDR_DRIVER_MODE: driver_mode <= req.wdata & MASK_DRIVER_MODE; // RULE_14
				ADDR_CARRIER_AMPLITUDE: carrier_amplitude <= req.wdata & MASK_CARRIER_AMPLITUDE; // RULE_14
				ADDR_MODULATION_CONTROL: modulation_control <= req.wdata;
				ADDR_OVERSHOOT_AND_LOAD: overshoot_and_load <= req.wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped addresses answer zero
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ADDR_DRIVER_MODE: rdata <= driver_mode;
				ADDR_CARRIER_AMPLITUDE: rdata <= carrier_amplitude;
				ADDR_MODULATION_CONTROL: rdata <= modulation_control;
				ADDR_OVERSHOOT_AND_LOAD: rdata <= overshoot_and_load;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// External modulation pin passes two flops before use
	always_ff @(posedge clock) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= external_modulation_input;
			ext_sync <= ext_meta;
		end
	end

	// Source pick and polarity; the reserved code acts as no modulation
	always_comb begin
		case (modulation_control[1:0])
			SRC_ENVELOPE: mod_sel = internal_envelope_signal; // RULE_09
			SRC_EXTERNAL: mod_sel = ext_sync; // RULE_09
			default: mod_sel = 1'b0; // RULE_09
		endcase
	end

	// Registered modulation so the pins change on a clean edge
	always_ff @(posedge clock) begin
		if (rst) begin
			modulation_active <= 1'b0;
			mod_prev <= 1'b0;
		end else begin
			modulation_active <= mod_sel ^ modulation_control[POS_MOD_POL]; // RULE_08
			mod_prev <= mod_sel;
		end
	end

	// Overshoot pulse after each modulation edge: first length on the falling
	// side, second length on the rising side; a length of zero gives no pulse
	always_ff @(posedge clock) begin
		if (rst) begin
			os_count <= 4'h0;
			os_phase_first <= 1'b0;
		end else if (mod_sel & ~mod_prev) begin
			os_count <= modulation_control[7:4]; // RULE_10
			os_phase_first <= 1'b0;
		end else if (~mod_sel & mod_prev) begin
			os_count <= overshoot_and_load[7:4]; // RULE_11
			os_phase_first <= 1'b1;
		end else if (os_count != 4'h0) begin
			os_count <= os_count - 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			overshoot_active <= 1'b0;
		end else begin
			overshoot_active <= (os_count != 4'h0); // RULE_10
		end
	end

	// Analog settings word held in flops
	always_ff @(posedge clock) begin
		if (rst) begin
			analog <= '0;
		end else begin
			analog.full_swing <= modulation_control[POS_FULL_SWING]; // RULE_07
			if (modulation_control[POS_FULL_SWING]) begin
				analog.carrier_drop_mv <= 11'h000; // RULE_07
			end else begin
				case (carrier_amplitude[7:6])
					2'h0: analog.carrier_drop_mv <= DROP_MV_0; // RULE_06
					2'h1: analog.carrier_drop_mv <= DROP_MV_1; // RULE_06
					2'h2: analog.carrier_drop_mv <= DROP_MV_2; // RULE_06
					default: analog.carrier_drop_mv <= DROP_MV_3; // RULE_06
				endcase
			end
			analog.residual_level <= carrier_amplitude[4:0]; // RULE_13
			analog.load_current_trim <= overshoot_and_load[3:0]; // RULE_12
			analog.overshoot_len_first <= overshoot_and_load[7:4]; // RULE_11
			analog.overshoot_len_second <= modulation_control[7:4]; // RULE_10
		end
	end

	// Pin level before style: carrier gated low by modulation, with polarity
	assign style = driver_mode[2:0];
	assign drive_a = ~modulation_active ^ driver_mode[POS_FIRST_POL]; // RULE_03
	assign drive_b = ~modulation_active ^ driver_mode[POS_SECOND_POL]; // RULE_02

	// Output style; unsupported codes fall back to high impedance as a safe state
	always_comb begin
		next_a_out = 1'b0;
		next_a_oe = 1'b0;
		next_b_out = 1'b0;
		next_b_oe = 1'b0;
		if (driver_mode[POS_OUTPUT_ON]) begin // RULE_01
			case (style)
				STYLE_OPEN_DRAIN: begin // RULE_05
					next_a_oe = ~drive_a;
					next_b_oe = ~drive_b;
				end
				STYLE_PUSH_PULL: begin // RULE_05
					next_a_out = drive_a;
					next_b_out = drive_b;
					next_a_oe = 1'b1;
					next_b_oe = 1'b1;
				end
				STYLE_FIXED_HIGH: begin // RULE_05
					next_a_out = 1'b1;
					next_b_out = 1'b1;
					next_a_oe = 1'b1;
					next_b_oe = 1'b1;
				end
				STYLE_FIXED_LOW: begin // RULE_05
					next_a_oe = 1'b1;
					next_b_oe = 1'b1;
				end
				default: ; // High-Z and the codes software must not use (RULE_04)
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			antenna_drive_a_out <= 1'b0;
			antenna_drive_a_oe <= 1'b0;
			antenna_drive_b_out <= 1'b0;
			antenna_drive_b_oe <= 1'b0;
		end else begin
			antenna_drive_a_out <= next_a_out;
			antenna_drive_a_oe <= next_a_oe;
			antenna_drive_b_out <= next_b_out;
			antenna_drive_b_oe <= next_b_oe;
		end
	end

	// Checks on the antenna pins
	// Driver off must release both pins whatever the style
	a_off_no_drive: assert property (@(posedge clock) disable iff (rst) // RULE_01
		!driver_mode[POS_OUTPUT_ON] |=> !antenna_drive_a_oe && !antenna_drive_b_oe)
		else $error("antenna driven while driver off");
	// Push-pull drives both pins every cycle
	a_pushpull_both_on: assert property (@(posedge clock) disable iff (rst) // RULE_05
		driver_mode[POS_OUTPUT_ON] && style == STYLE_PUSH_PULL |=> antenna_drive_a_oe && antenna_drive_b_oe)
		else $error("push-pull did not drive both pins");
	// Second pin follows its polarity bit
	a_second_polarity: assert property (@(posedge clock) disable iff (rst) // RULE_02
		driver_mode[POS_OUTPUT_ON] && style == STYLE_PUSH_PULL |=> antenna_drive_b_out == $past(drive_b))
		else $error("second pin polarity wrong");
	// First pin level worked out from the polarity bit and the modulation level
	a_first_polarity: assert property (@(posedge clock) disable iff (rst) // RULE_03
		driver_mode[POS_OUTPUT_ON] && style == STYLE_PUSH_PULL
		|=> antenna_drive_a_out == ($past(driver_mode[POS_FIRST_POL]) ^ ~$past(modulation_active)))
		else $error("first pin polarity wrong");

	// Open drain only ever pulls low
	a_open_drain_low: assert property (@(posedge clock) disable iff (rst) // RULE_05
		driver_mode[POS_OUTPUT_ON] && style == STYLE_OPEN_DRAIN
		|=> !antenna_drive_a_out && !antenna_drive_b_out && antenna_drive_a_oe == !$past(drive_a))
		else $error("open drain pin level wrong");
	// High-Z and the codes software must avoid leave both pins released
	a_high_z_release: assert property (@(posedge clock) disable iff (rst) // RULE_05
		driver_mode[POS_OUTPUT_ON] && (style == STYLE_HIGH_Z || style == STYLE_UNSUPPORTED_A
		|| style == STYLE_UNSUPPORTED_B) |=> !antenna_drive_a_oe && !antenna_drive_b_oe)
		else $error("released style still drives");
	// Fixed high ignores modulation
	a_fixed_high: assert property (@(posedge clock) disable iff (rst) // RULE_05
		driver_mode[POS_OUTPUT_ON] && style == STYLE_FIXED_HIGH
		|=> antenna_drive_a_oe && antenna_drive_b_oe && antenna_drive_a_out && antenna_drive_b_out)
		else $error("fixed high level wrong");
	// Fixed low ignores modulation
	a_fixed_low: assert property (@(posedge clock) disable iff (rst) // RULE_05
		driver_mode[POS_OUTPUT_ON] && style == STYLE_FIXED_LOW
		|=> antenna_drive_a_oe && antenna_drive_b_oe && !antenna_drive_a_out && !antenna_drive_b_out)
		else $error("fixed low level wrong");

	// Checks on the analog settings word
	// Full swing forces zero reduction
	a_full_swing_wins: assert property (@(posedge clock) disable iff (rst) // RULE_07
		modulation_control[POS_FULL_SWING] |=> analog.carrier_drop_mv == 11'h000)
		else $error("full swing did not override level");
	// Full swing flag copies the register bit
	a_swing_flag: assert property (@(posedge clock) disable iff (rst) // RULE_07
		1'b1 |=> analog.full_swing == $past(modulation_control[POS_FULL_SWING]))
		else $error("full swing flag wrong");
	// Level code 0 gives the smallest reduction
	a_level_min_drop: assert property (@(posedge clock) disable iff (rst) // RULE_06
		!modulation_control[POS_FULL_SWING] && carrier_amplitude[7:6] == 2'h0 |=> analog.carrier_drop_mv == DROP_MV_0)
		else $error("carrier drop code 0 wrong");
	// Level code 1
	a_level_code_one: assert property (@(posedge clock) disable iff (rst) // RULE_06
		!modulation_control[POS_FULL_SWING] && carrier_amplitude[7:6] == 2'h1 |=> analog.carrier_drop_mv == DROP_MV_1)
		else $error("carrier drop code 1 wrong");
	// Level code 2
	a_level_code_two: assert property (@(posedge clock) disable iff (rst) // RULE_06
		!modulation_control[POS_FULL_SWING] && carrier_amplitude[7:6] == 2'h2 |=> analog.carrier_drop_mv == DROP_MV_2)
		else $error("carrier drop code 2 wrong");
	// Level code 3 gives the largest reduction
	a_level_max_drop: assert property (@(posedge clock) disable iff (rst) // RULE_06
		!modulation_control[POS_FULL_SWING] && carrier_amplitude[7:6] == 2'h3 |=> analog.carrier_drop_mv == DROP_MV_3)
		else $error("carrier drop code 3 wrong");
	// Residual carrier level passes through unchanged
	a_residual_copy: assert property (@(posedge clock) disable iff (rst) // RULE_13
		1'b1 |=> analog.residual_level == $past(carrier_amplitude[4:0]))
		else $error("residual level wrong");
	// Load current trim passes through unchanged
	a_trim_copy: assert property (@(posedge clock) disable iff (rst) // RULE_12
		1'b1 |=> analog.load_current_trim == $past(overshoot_and_load[3:0]))
		else $error("load current trim wrong");
	// First overshoot length passes through unchanged
	a_first_len_copy: assert property (@(posedge clock) disable iff (rst) // RULE_11
		1'b1 |=> analog.overshoot_len_first == $past(overshoot_and_load[7:4]))
		else $error("first overshoot length wrong");
	// Second overshoot length passes through unchanged
	a_second_len_copy: assert property (@(posedge clock) disable iff (rst) // RULE_10
		1'b1 |=> analog.overshoot_len_second == $past(modulation_control[7:4]))
		else $error("second overshoot length copy wrong");

	// Checks on the modulation path
	// No source leaves only the polarity bit
	a_no_source_idle: assert property (@(posedge clock) disable iff (rst) // RULE_09
		modulation_control[1:0] == SRC_NONE |=> modulation_active == $past(modulation_control[POS_MOD_POL]))
		else $error("modulation present with no source");
	// Reserved source behaves as no modulation
	a_reserved_source: assert property (@(posedge clock) disable iff (rst) // RULE_09
		modulation_control[1:0] == 2'h3 |=> modulation_active == $past(modulation_control[POS_MOD_POL]))
		else $error("reserved source modulates");
	// Envelope source with polarity
	a_mod_polarity: assert property (@(posedge clock) disable iff (rst) // RULE_08
		modulation_control[1:0] == SRC_ENVELOPE
		|=> modulation_active == ($past(internal_envelope_signal) ^ $past(modulation_control[POS_MOD_POL])))
		else $error("modulation polarity wrong");
	// External source after the synchroniser, with polarity
	a_external_source: assert property (@(posedge clock) disable iff (rst) // RULE_09
		modulation_control[1:0] == SRC_EXTERNAL
		|=> modulation_active == ($past(ext_sync) ^ $past(modulation_control[POS_MOD_POL])))
		else $error("external source path wrong");

	// Checks on the overshoot pulse
	// Rising source edge with a nonzero second length raises the pulse
	a_overshoot_len: assert property (@(posedge clock) disable iff (rst) // RULE_10
		mod_sel && !mod_prev && modulation_control[7:4] != 4'h0 |=> ##1 overshoot_active)
		else $error("second overshoot length wrong");
	// Falling source edge with a nonzero first length raises the pulse
	a_fall_overshoot: assert property (@(posedge clock) disable iff (rst) // RULE_11
		!mod_sel && mod_prev && overshoot_and_load[7:4] != 4'h0 |=> ##1 overshoot_active)
		else $error("first overshoot length wrong");

	// Reserved bits never hold a one and read back as zero
	a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // RULE_14
		(driver_mode[5:4] == 2'h0) && (carrier_amplitude[5] == 1'b0))
		else $error("reserved bits not zero");
	// Read of the mode register shows the reserved pair as zero
	a_read_reserved: assert property (@(posedge clock) disable iff (rst) // RULE_14
		req.rd && req.addr == ADDR_DRIVER_MODE |=> rdata[5:4] == 2'h0)
		else $error("reserved bits read back set");

	// Main scenarios worth seeing at least once
	c_push_pull: cover property (@(posedge clock) antenna_drive_a_oe && antenna_drive_b_oe && antenna_drive_a_out);
	c_fixed_low: cover property (@(posedge clock) style == STYLE_FIXED_LOW && antenna_drive_a_oe);
	c_overshoot: cover property (@(posedge clock) overshoot_active && os_phase_first);
	c_external_mod: cover property (@(posedge clock) modulation_control[1:0] == SRC_EXTERNAL && modulation_active);
	c_open_drain: cover property (@(posedge clock) style == STYLE_OPEN_DRAIN && antenna_drive_a_oe);
endmodule : rtd_bank
`default_nettype wire

// ---- sim/rtd_antenna.sv ----
// Purpose: Matching network seen through the two antenna drive pins
// Assumes: Pins sampled on the system clock
// Notes: An undriven pin toggles so a stale level never looks valid
`default_nettype none
module rtd_antenna (
	input wire logic clock,
	input wire logic drive_a_out,
	input wire logic drive_a_oe,
	input wire logic drive_b_out,
	input wire logic drive_b_oe,
	output logic pin_a,
	output logic pin_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_a = 1'b0;
	logic last_b = 1'b0;
	// Released pin shows the inverse of its last level
	assign pin_a = drive_a_oe ? drive_a_out : ~last_a;
	assign pin_b = drive_b_oe ? drive_b_out : ~last_b;
	// Remember the level for the floating case
	always_ff @(posedge clock) begin
		last_a <= pin_a;
		last_b <= pin_b;
	end
endmodule : rtd_antenna
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the transmitter driver bank
// Assumes: Byte register port, read data one cycle after the strobe
// Notes: Style codes 011b and 110b are never written; t_regs writes 111b to the mode register
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rtd_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic env = 1'b0;
	logic ext = 1'b0;
	rtd_req_t req = '0;
	logic [7:0] rdata;
	logic a_out, a_oe, b_out, b_oe, mod_act, ovs_act, pin_a, pin_b;
	rtd_analog_t analog;
	int num_errors = 0;
	int checked = 0;
	// Free-running 250 MHz clock
	initial begin
		forever #2 clock = ~clock;
	end
	rtd_bank DUT (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .internal_envelope_signal(env),
		.external_modulation_input(ext), .antenna_drive_a_out(a_out), .antenna_drive_a_oe(a_oe),
		.antenna_drive_b_out(b_out), .antenna_drive_b_oe(b_oe), .modulation_active(mod_act),
		.overshoot_active(ovs_act), .analog(analog));
	rtd_antenna antenna (.clock(clock), .drive_a_out(a_out), .drive_a_oe(a_oe), .drive_b_out(b_out),
		.drive_b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));
	task end_of_test;
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Write strobe, then wait until pins and analog word have followed
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req <= '0;
		repeat (2) @(posedge clock);
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req <= '0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd
	// Bounded wait of up to 10 cycles for the modulation level; the sync chain is two flops
	task wait_mod(input logic v);
		int n;
		n = 0;
		while (mod_act !== v && n < 10) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("mod_act", v, mod_act)
		if (n == 10) end_of_test();
	endtask : wait_mod
	task count_ovs(input logic v, output int c);
		c = 0;
		@(posedge clock);
		env <= v;
		repeat (20) begin
			@(posedge clock);
			#1;
			if (ovs_act === 1'b1) c++;
		end
	endtask : count_ovs
	task t_regs;
		logic [7:0] m [4];
		m = '{MASK_DRIVER_MODE, MASK_CARRIER_AMPLITUDE, 8'hFF, 8'hFF};
		for (int i = 0; i < 4; i++) rd(8'h28 + i[7:0], 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'h28 + i[7:0], 8'hFF);
			rd(8'h28 + i[7:0], m[i]);
		end
		wr(8'h2C, 8'hFF);
		rd(8'h2C, 8'h00);
		for (int i = 0; i < 4; i++) wr(8'h28 + i[7:0], 8'h00);
	endtask : t_regs
	task t_pins;
		logic [7:0] d [6];
		logic [1:0] e [6];
		d = '{8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h48, 8'h09};
		e = '{2'b00, 2'b00, 2'b11, 2'b10, 2'b10, 2'b11};
		wr(8'h28, 8'h09);
		`CHK("oe", 4'hF, {a_oe, b_oe, pin_a, pin_b})
		wr(8'h28, 8'h89);
		`CHK("pins", 2'b10, {pin_a, pin_b})
		wr(8'h28, 8'h49);
		`CHK("pins", 2'b01, {pin_a, pin_b})
		wr(8'h28, 8'h01);
		`CHK("oe", 2'b00, {a_oe, b_oe})
		for (int i = 0; i < 6; i++) begin
			wr(8'h28, d[i]);
			`CHK("style", e[i], {a_oe, a_oe & pin_a})
		end
	endtask : t_pins
	task t_analog;
		logic [10:0] t [4];
		t = '{DROP_MV_0, DROP_MV_1, DROP_MV_2, DROP_MV_3};
		for (int i = 0; i < 4; i++) begin
			wr(8'h29, {i[1:0], 1'b0, 5'h11 + i[4:0]});
			`CHK("drop", t[i], analog.carrier_drop_mv)
			`CHK("resid", 5'h11 + i[4:0], analog.residual_level)
		end
		wr(8'h2A, 8'h08);
		`CHK("swing", 12'h800, {analog.full_swing, analog.carrier_drop_mv})
	endtask : t_analog
	task t_mod;
		@(posedge clock);
		env <= 1'b1;
		wr(8'h2A, 8'h01);
		wait_mod(1'b1);
		wr(8'h2A, 8'h05);
		wait_mod(1'b0);
		@(posedge clock);
		env <= 1'b0;
		ext <= 1'b1;
		wr(8'h2A, 8'h02);
		wait_mod(1'b1);
		wr(8'h2A, 8'h03);
		wait_mod(1'b0);
		wr(8'h2A, 8'h00);
		@(posedge clock);
		ext <= 1'b0;
		wait_mod(1'b0);
	endtask : t_mod
	task t_ovs;
		int c;
		wr(8'h2B, 8'h35);
		wr(8'h2A, 8'h41);
		`CHK("first", 4'h3, analog.overshoot_len_first)
		`CHK("trim", 4'h5, analog.load_current_trim)
		`CHK("second", 4'h4, analog.overshoot_len_second)
		count_ovs(1'b1, c);
		`CHK("ovs_rise", 4, c)
		count_ovs(1'b0, c);
		`CHK("ovs_fall", 3, c)
	endtask : t_ovs
	// Reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_pins();
		t_analog();
		t_mod();
		t_ovs();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
